// file: inc/dps_pkg.sv
/*
  Package for the default sequencer program store: entry layout, the
  fixed default entries, register map of the local port and wait times.
  Assumes a 125 MHz system clock and a sequencer engine that fetches by index.
*/
// How it works
// RULE1 - entry 28 sets all headphone bits 5Ah
// RULE2 - entry 29 sets line outputs, ends start-up
// RULE3 - shut-down starts at 32, line 77h
// RULE4 - 33 headphone 77h, then 34/35 zero
// RULE5 - entries 37..43 clear pump through bias
// RULE6 - entry 44 sets reference soft ramp 2
// RULE7 - entry 45 clears buffer, waits 256ms
// RULE8 - entry 46 clears buffer, waits 32ms
// RULE9 - entry 47 zeroes whole reference register
// RULE10 - entry 48 clears biases, ends shut-down
// RULE11 - entry 23 enables four servos, 256ms
// RULE12 - engine writes field, delays, stops at end
package dps_pkg;

  typedef struct packed {
    logic [7:0] reg_addr;
    logic [3:0] width;
    logic [2:0] start;
    logic end_of_sequence_flag;
    logic [3:0] delay;
    logic [7:0] data;
  } dps_entry_t;

  typedef struct packed {
    logic known;
    dps_entry_t entry;
  } dps_lookup_t;

  typedef enum logic [1:0] {
    DPS_DLY_IDLE = 2'b01,
    DPS_DLY_COUNT = 2'b10
  } dps_dly_state_t;

  // default entries: reg, width, start, end flag, delay code, data
  localparam dps_entry_t DPS_E23 = '{8'h43, 4'h4, 3'h0, 1'b0, 4'hC, 8'h0F};
  localparam dps_entry_t DPS_E28 = '{8'h5A, 4'h8, 3'h0, 1'b0, 4'h0, 8'hFF};
  localparam dps_entry_t DPS_E29 = '{8'h5E, 4'h8, 3'h0, 1'b1, 4'h0, 8'hFF};
  localparam dps_entry_t DPS_ESPARE = '{8'hFF, 4'h1, 3'h0, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E32 = '{8'h5E, 4'h8, 3'h0, 1'b0, 4'h0, 8'h77};
  localparam dps_entry_t DPS_E33 = '{8'h5A, 4'h8, 3'h0, 1'b0, 4'h0, 8'h77};
  localparam dps_entry_t DPS_E34 = '{8'h5A, 4'h8, 3'h0, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E35 = '{8'h5E, 4'h8, 3'h0, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E36 = '{8'h43, 4'h4, 3'h0, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E37 = '{8'h62, 4'h1, 3'h0, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E38 = '{8'h12, 4'h2, 3'h2, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E39 = '{8'h16, 4'h1, 3'h1, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E40 = '{8'h0E, 4'h2, 3'h0, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E41 = '{8'h0F, 4'h2, 3'h0, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E42 = '{8'h0D, 4'h2, 3'h0, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E43 = '{8'h04, 4'h1, 3'h0, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E44 = '{8'h05, 4'h2, 3'h3, 1'b0, 4'h0, 8'h02};
  localparam dps_entry_t DPS_E45 = '{8'h05, 4'h1, 3'h0, 1'b0, 4'hC, 8'h00};
  localparam dps_entry_t DPS_E46 = '{8'h05, 4'h1, 3'h0, 1'b0, 4'h9, 8'h00};
  localparam dps_entry_t DPS_E47 = '{8'h05, 4'h8, 3'h0, 1'b0, 4'h0, 8'h00};
  localparam dps_entry_t DPS_E48 = '{8'h04, 4'h2, 3'h0, 1'b1, 4'h0, 8'h00};
  localparam dps_entry_t DPS_ENULL = '0;

  // delay codes with a known wait
  localparam logic [3:0] DPS_DLY_NONE = 4'h0;
  localparam logic [3:0] DPS_DLY_LONG = 4'hC;
  localparam logic [3:0] DPS_DLY_SHORT = 4'h9;

  // wait times in ms and their cycle counts at the system clock
  localparam int unsigned DPS_CLK_KHZ = 125000;
  localparam int unsigned DPS_WAIT_LONG_MS = 256;
  localparam int unsigned DPS_WAIT_SHORT_MS = 32;
  localparam int unsigned DPS_WAIT_LONG_CYC = DPS_WAIT_LONG_MS * DPS_CLK_KHZ;
  localparam int unsigned DPS_WAIT_SHORT_CYC = DPS_WAIT_SHORT_MS * DPS_CLK_KHZ;
  localparam int DPS_CNT_W = 25;

  // local register map, byte addresses
  localparam logic [7:0] DPS_REG_CTRL = 8'h00;
  localparam logic [7:0] DPS_REG_STATUS = 8'h04;
  localparam logic [7:0] DPS_REG_FETCH_COUNT = 8'h08;
  localparam logic [7:0] DPS_REG_TABLE_INDEX = 8'h0C;
  localparam logic [7:0] DPS_REG_TABLE_ENTRY = 8'h10;
  localparam logic [7:0] DPS_REG_DELAY_LEFT = 8'h14;

  // field positions
  localparam int DPS_CTRL_STORE_EN = 0;
  localparam int DPS_CTRL_CLR_COUNT = 1;
  localparam int DPS_CTRL_CLR_UNKNOWN = 2;
  localparam int DPS_ST_BUSY = 0;
  localparam int DPS_ST_KNOWN = 1;
  localparam int DPS_ST_EOS = 2;
  localparam int DPS_ST_UNKNOWN_DLY = 3;
  localparam int DPS_ST_INDEX = 8;

  localparam logic DPS_STORE_EN_RST = 1'b1;

endpackage

// file: hw/dps_store.sv
/*
  Default program store for the control write sequencer, entries 23 and
  28 to 48, with field mask/value shaping and the wait timer for the
  entry just applied, plus a small register port for control and status.
  Assumes the engine drives fetch and delay strobes synchronous to mclk_i.
*/
`timescale 1ns/1ps

module dps_store
  import dps_pkg::*;
#(
  parameter int unsigned WAIT_LONG_CYC = DPS_WAIT_LONG_CYC,
  parameter int unsigned WAIT_SHORT_CYC = DPS_WAIT_SHORT_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // engine fetch
  input wire logic fetch_req_i,
  input wire logic [5:0] sequencer_entry_index_i,
  output dps_entry_t entry_o,
  output logic entry_valid_o,
  output logic entry_known_o,
  output logic [15:0] field_mask_o,
  output logic [15:0] field_value_o,
  // engine wait
  input wire logic delay_start_i,
  output logic delay_busy_o
);

  typedef struct packed {
    dps_dly_state_t dly_state;
    logic [DPS_CNT_W-1:0] dly_count;
    logic delay_busy;
    logic store_en;
    logic [5:0] tbl_index;
    logic [5:0] last_index;
    logic last_known;
    logic eos_seen;
    logic unknown_dly;
    logic [31:0] fetch_count;
    logic [31:0] rdata;
    dps_entry_t entry;
    logic entry_valid;
    logic entry_known;
    logic [15:0] field_mask;
    logic [15:0] field_value;
  } dps_state_t;

  localparam dps_state_t STATE_RST = '{
    dly_state: DPS_DLY_IDLE,
    dly_count: '0,
    delay_busy: 1'b0,
    store_en: DPS_STORE_EN_RST,
    tbl_index: '0,
    last_index: '0,
    last_known: 1'b0,
    eos_seen: 1'b0,
    unknown_dly: 1'b0,
    fetch_count: '0,
    rdata: '0,
    entry: DPS_ENULL,
    entry_valid: 1'b0,
    entry_known: 1'b0,
    field_mask: '0,
    field_value: '0
  };

  localparam logic [DPS_CNT_W-1:0] LONG_LOAD = DPS_CNT_W'(WAIT_LONG_CYC - 1);
  localparam logic [DPS_CNT_W-1:0] SHORT_LOAD = DPS_CNT_W'(WAIT_SHORT_CYC - 1);

  dps_state_t s;
  dps_state_t next_s;

  // indexes outside the held range report unknown with a null entry
  function automatic dps_lookup_t lookup(input logic [5:0] idx);
    dps_lookup_t r;
    r.known = 1'b1;
    case (idx)
      6'd23: r.entry = DPS_E23; // [RULE11]
      6'd28: r.entry = DPS_E28; // [RULE1]
      6'd29: r.entry = DPS_E29; // [RULE2]
      6'd30: r.entry = DPS_ESPARE;
      6'd31: r.entry = DPS_ESPARE;
      6'd32: r.entry = DPS_E32; // [RULE3]
      6'd33: r.entry = DPS_E33; // [RULE4]
      6'd34: r.entry = DPS_E34; // [RULE4]
      6'd35: r.entry = DPS_E35; // [RULE4]
      6'd36: r.entry = DPS_E36;
      6'd37: r.entry = DPS_E37; // [RULE5]
      6'd38: r.entry = DPS_E38; // [RULE5]
      6'd39: r.entry = DPS_E39; // [RULE5]
      6'd40: r.entry = DPS_E40; // [RULE5]
      6'd41: r.entry = DPS_E41; // [RULE5]
      6'd42: r.entry = DPS_E42; // [RULE5]
      6'd43: r.entry = DPS_E43; // [RULE5]
      6'd44: r.entry = DPS_E44; // [RULE6]
      6'd45: r.entry = DPS_E45; // [RULE7]
      6'd46: r.entry = DPS_E46; // [RULE8]
      6'd47: r.entry = DPS_E47; // [RULE9]
      6'd48: r.entry = DPS_E48; // [RULE10]
      default: begin
        r.known = 1'b0;
        r.entry = DPS_ENULL;
      end
    endcase
    return r;
  endfunction

  // field of the given width placed at the start bit of a 16-bit register
  function automatic logic [15:0] field_mask(input dps_entry_t e);
    logic [15:0] low;
    low = 16'(({1'b0, 16'hFFFF} << e.width) ^ {1'b0, 16'hFFFF}) & 16'hFFFF;
    return 16'(low << e.start);
  endfunction

  function automatic logic [15:0] field_value(input dps_entry_t e);
    logic [15:0] low;
    low = 16'(({1'b0, 16'hFFFF} << e.width) ^ {1'b0, 16'hFFFF}) & 16'hFFFF;
    return 16'(({8'h00, e.data} & low) << e.start);
  endfunction

  function automatic logic [31:0] pack_entry(input dps_entry_t e);
    return {4'h0, e};
  endfunction

  dps_lookup_t fetch_look;
  dps_lookup_t tbl_look;
  logic unk_set;

  always_comb begin
    unk_set = 1'b0;
    fetch_look = lookup(sequencer_entry_index_i);
    tbl_look = lookup(s.tbl_index);
    next_s = s;
    next_s.entry_valid = 1'b0;
    next_s.rdata = '0;

    // engine fetch; a disabled store answers with an unknown null entry
    if (fetch_req_i) begin
      next_s.entry_valid = 1'b1;
      next_s.last_index = sequencer_entry_index_i;
      next_s.fetch_count = s.fetch_count + 32'h0000_0001;
      if (s.store_en && fetch_look.known) begin
        next_s.entry = fetch_look.entry;
        next_s.entry_known = 1'b1;
        next_s.field_mask = field_mask(fetch_look.entry); // [RULE12]
        next_s.field_value = field_value(fetch_look.entry); // [RULE12]
        next_s.eos_seen = fetch_look.entry.end_of_sequence_flag; // [RULE12]
      end else begin
        next_s.entry = DPS_ENULL;
        next_s.entry_known = 1'b0;
        next_s.field_mask = '0;
        next_s.field_value = '0;
        next_s.eos_seen = 1'b0;
      end
      next_s.last_known = next_s.entry_known;
    end

    // wait timer for the entry held on entry_o
    case (s.dly_state)
      DPS_DLY_IDLE: begin
        if (delay_start_i && s.entry_known) begin
          if (s.entry.delay == DPS_DLY_LONG) begin
            next_s.dly_count = LONG_LOAD; // [RULE7] [RULE11]
            next_s.dly_state = DPS_DLY_COUNT;
            next_s.delay_busy = 1'b1;
          end else if (s.entry.delay == DPS_DLY_SHORT) begin
            next_s.dly_count = SHORT_LOAD; // [RULE8]
            next_s.dly_state = DPS_DLY_COUNT;
            next_s.delay_busy = 1'b1;
          end else if (s.entry.delay != DPS_DLY_NONE) begin
            // codes with no known wait are flagged, not guessed
            next_s.unknown_dly = 1'b1;
            unk_set = 1'b1;
          end
        end
      end
      DPS_DLY_COUNT: begin
        if (s.dly_count == '0) begin
          next_s.dly_state = DPS_DLY_IDLE;
          next_s.delay_busy = 1'b0;
        end else begin
          next_s.dly_count = s.dly_count - DPS_CNT_W'(1);
        end
      end
      default: begin
        next_s.dly_state = DPS_DLY_IDLE;
        next_s.delay_busy = 1'b0;
        next_s.dly_count = '0;
      end
    endcase

    // register writes; a flag set in the same cycle beats the clear
    if (reg_wr_i) begin
      case (reg_addr_i)
        DPS_REG_CTRL: begin
          next_s.store_en = reg_wdata_i[DPS_CTRL_STORE_EN];
          if (reg_wdata_i[DPS_CTRL_CLR_COUNT]) begin
            next_s.fetch_count = fetch_req_i ? 32'h0000_0001 : 32'h0000_0000;
          end
          if (reg_wdata_i[DPS_CTRL_CLR_UNKNOWN] && !unk_set) begin
            next_s.unknown_dly = 1'b0;
          end
        end
        DPS_REG_TABLE_INDEX: begin
          next_s.tbl_index = reg_wdata_i[5:0];
        end
        default: begin
        end
      endcase
    end

    // register reads, data stand only in the next cycle
    if (reg_rd_i) begin
      case (reg_addr_i)
        DPS_REG_CTRL: next_s.rdata = {31'h0000_0000, s.store_en};
        DPS_REG_STATUS: begin
          next_s.rdata[DPS_ST_BUSY] = s.delay_busy;
          next_s.rdata[DPS_ST_KNOWN] = s.last_known;
          next_s.rdata[DPS_ST_EOS] = s.eos_seen;
          next_s.rdata[DPS_ST_UNKNOWN_DLY] = s.unknown_dly;
          next_s.rdata[DPS_ST_INDEX +: 6] = s.last_index;
        end
        DPS_REG_FETCH_COUNT: next_s.rdata = s.fetch_count;
        DPS_REG_TABLE_INDEX: next_s.rdata = {26'h000_0000, s.tbl_index};
        DPS_REG_TABLE_ENTRY: next_s.rdata = tbl_look.known ? pack_entry(tbl_look.entry) : 32'h0000_0000;
        DPS_REG_DELAY_LEFT: next_s.rdata = {7'h00, s.dly_count};
        default: next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_o = s.rdata;
  assign entry_o = s.entry;
  assign entry_valid_o = s.entry_valid;
  assign entry_known_o = s.entry_known;
  assign field_mask_o = s.field_mask;
  assign field_value_o = s.field_value;
  assign delay_busy_o = s.delay_busy;

endmodule

// file: testbench/dps_store_asserts.sv
/* Port checker for dps_store.
   Sees only store ports; bound to every dps_store instance below. */
`timescale 1ns/1ps
module dps_store_asserts
  import dps_pkg::*;
#(
  parameter int unsigned WAIT_LONG_CYC = 20,
  parameter int unsigned WAIT_SHORT_CYC = 5
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // fetch
  input wire logic fetch_req_i,
  input wire logic [5:0] sequencer_entry_index_i,
  input wire dps_entry_t entry_o,
  input wire logic entry_valid_o,
  input wire logic entry_known_o,
  input wire logic [15:0] field_mask_o,
  input wire logic [15:0] field_value_o,
  // wait
  input wire logic delay_start_i,
  input wire logic delay_busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  int unsigned run;
  // length of the current busy stretch, cleared in the cycle after its fall
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) run <= 0;
    else run <= delay_busy_o ? run + 1 : 0;
  end
  property p_ent(logic [5:0] i, logic [27:0] v);
    fetch_req_i && sequencer_entry_index_i == i |=> (entry_known_o ? entry_o == v : entry_o == 28'h0000000);
  endproperty
  AST_E29: assert property (p_ent(6'd29, 28'h5E810FF))
    else $error("entry 29 wrong");
  AST_E32: assert property (p_ent(6'd32, 28'h5E80077))
    else $error("entry 32 wrong");
  AST_E45: assert property (p_ent(6'd45, 28'h0510C00))
    else $error("entry 45 wrong");
  AST_E48: assert property (p_ent(6'd48, 28'h0421000))
    else $error("entry 48 wrong");
  AST_VALID: assert property (fetch_req_i |=> entry_valid_o ##1 !entry_valid_o || $past(fetch_req_i))
    else $error("entry pulse wrong");
  AST_MASK: assert property (entry_valid_o && entry_known_o |->
    field_mask_o == 16'(((17'h1 << entry_o.width) - 17'h1) << entry_o.start))
    else $error("field mask wrong");
  AST_VALUE: assert property (entry_valid_o && entry_known_o |->
    field_value_o == 16'(({9'h000, entry_o.data} & ((17'h1 << entry_o.width) - 17'h1)) << entry_o.start))
    else $error("field value wrong");
  AST_BUSY_START: assert property (delay_start_i && !delay_busy_o && entry_known_o &&
    entry_o.delay == 4'h9 |=> delay_busy_o)
    else $error("wait did not start");
  AST_NO_WAIT: assert property (delay_start_i && !delay_busy_o && entry_o.delay == 4'h0 |=> !delay_busy_o)
    else $error("wait on code zero");
  AST_BUSY_LEN: assert property ($fell(delay_busy_o) |->
    run == (entry_o.delay == 4'hC ? WAIT_LONG_CYC : WAIT_SHORT_CYC))
    else $error("wait length wrong");
  C_END: cover property (fetch_req_i && sequencer_entry_index_i == 6'd48);
  C_WAIT: cover property ($fell(delay_busy_o));
  C_STEP: cover property (fetch_req_i ##1 fetch_req_i);
endmodule
bind dps_store dps_store_asserts #(.WAIT_LONG_CYC(WAIT_LONG_CYC), .WAIT_SHORT_CYC(WAIT_SHORT_CYC)) u_dps_store_asserts (
  .mclk_i, .arst_n_i, .fetch_req_i, .sequencer_entry_index_i, .entry_o, .entry_valid_o,
  .entry_known_o, .field_mask_o, .field_value_o, .delay_start_i, .delay_busy_o);

// file: testbench/dps_engine_model.sv
/* Behavioural sequencer engine: fetches by index, starts each wait, stops on the end flag.
   Assumes the store answers a fetch one cycle later. */
`timescale 1ns/1ps
module dps_engine_model
  import dps_pkg::*;
(
  // control
  input wire logic mclk_i,
  input wire logic run_i,
  input wire logic slow_i,
  input wire logic [5:0] first_i,
  output logic done_o,
  // store side
  input wire dps_entry_t entry_i,
  input wire logic known_i,
  input wire logic busy_i,
  output logic fetch_req_o,
  output logic [5:0] index_o,
  output logic delay_start_o
);
  logic [5:0] idx;
  logic fin;
  int n;
  initial begin
    done_o = 1'b1;
    fetch_req_o = 1'b0;
    index_o = 6'h00;
    delay_start_o = 1'b0;
  end
  always begin
    @(posedge mclk_i);
    if (run_i) begin
      done_o <= 1'b0;
      idx = first_i;
      fin = 1'b0;
      while (!fin) begin
        fetch_req_o <= 1'b1;
        index_o <= idx;
        @(posedge mclk_i);
        fetch_req_o <= 1'b0;
        // index is meaningless between fetches
        index_o <= ~idx;
        @(posedge mclk_i);
        repeat (slow_i ? 3 : 0) @(posedge mclk_i);
        // code zero is offered as well; the store must not wait on it
        delay_start_o <= known_i;
        @(posedge mclk_i);
        delay_start_o <= 1'b0;
        @(posedge mclk_i);
        for (n = 0; n < 1000 && busy_i; n++) @(posedge mclk_i);
        fin = entry_i.end_of_sequence_flag || idx == 6'h3F;
        idx = idx + 6'h01;
      end
      done_o <= 1'b1;
    end
  end
endmodule

// file: testbench/testbench.sv
/* Self-checking bench for dps_store: engine model on the fetch and wait pins,
   register master on the local port; waits shortened by parameter. */
`timescale 1ns/1ps
module testbench;
  import dps_pkg::*;
  localparam int unsigned LW = 20;
  localparam int unsigned SW = 5;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic eng_run = 1'b0;
  logic eng_slow = 1'b0;
  logic [5:0] eng_first = 6'h00;
  logic [31:0] reg_rdata;
  logic eng_done, fetch_req, delay_start, valid, known, busy;
  logic [5:0] index;
  logic [15:0] fmask;
  logic [15:0] fval;
  dps_entry_t entry;
  int mismatches = 0;
  int n_tests = 0;
  int busy_cyc = 0;
  logic [28:0] seen [$];
  logic [27:0] tbl [23:48] = '{28'h4340C0F, 28'h0, 28'h0, 28'h0, 28'h0, 28'h5A800FF, 28'h5E810FF,
    28'hFF10000, 28'hFF10000, 28'h5E80077, 28'h5A80077, 28'h5A80000, 28'h5E80000, 28'h4340000,
    28'h6210000, 28'h1224000, 28'h1612000, 28'h0E20000, 28'h0F20000, 28'h0D20000, 28'h0410000,
    28'h0526002, 28'h0510C00, 28'h0510900, 28'h0580000, 28'h0421000};
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (valid) seen.push_back({known, entry});
    if (busy) busy_cyc++;
  end
  dps_store #(.WAIT_LONG_CYC(LW), .WAIT_SHORT_CYC(SW)) u_dps_store (.mclk_i, .arst_n_i,
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .fetch_req_i(fetch_req), .sequencer_entry_index_i(index),
    .entry_o(entry), .entry_valid_o(valid), .entry_known_o(known), .field_mask_o(fmask),
    .field_value_o(fval), .delay_start_i(delay_start), .delay_busy_o(busy));
  dps_engine_model u_dps_engine_model (.mclk_i, .run_i(eng_run), .slow_i(eng_slow),
    .first_i(eng_first), .done_o(eng_done), .entry_i(entry), .known_i(known), .busy_i(busy),
    .fetch_req_o(fetch_req), .index_o(index), .delay_start_o(delay_start));
  task automatic results;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge mclk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    #1 chk(name, reg_rdata, exp);
  endtask
  task automatic run(input logic [5:0] first, input logic slow);
    int n;
    seen.delete();
    busy_cyc = 0;
    @(posedge mclk_i);
    eng_run <= 1'b1;
    eng_first <= first;
    eng_slow <= slow;
    @(posedge mclk_i);
    eng_run <= 1'b0;
    @(posedge mclk_i);
    for (n = 0; n < 20000 && !eng_done; n++) @(posedge mclk_i);
    if (!eng_done) begin
      mismatches++;
      results();
    end
  endtask
  // compare every fetched entry with the table, or with zero when refused
  task automatic chk_run(input int first, input int last, input logic en);
    int i;
    logic [28:0] e;
    chk("fetches", seen.size(), last - first + 1);
    for (i = first; i <= last; i++) begin
      e = (en && (i == 23 || (i >= 28 && i <= 48))) ? {1'b1, tbl[i]} : 29'h0;
      chk($sformatf("entry %0d", i), seen[i - first], e);
    end
  endtask
  task automatic t_reset;
    rd(DPS_REG_CTRL, 32'h1, "ctrl");
    rd(DPS_REG_STATUS, 32'h0, "status");
    rd(8'hFC, 32'h0, "unmapped");
  endtask
  task automatic t_startup;
    run(6'd23, 1'b1);
    chk_run(23, 29, 1'b1);
    chk("startup wait", busy_cyc, LW);
    chk("mask 29", fmask, 32'h0000_00FF);
    chk("value 29", fval, 32'h0000_00FF);
    rd(DPS_REG_STATUS, 32'h1D06, "status end");
  endtask
  task automatic t_shutdown;
    run(6'd32, 1'b0);
    chk_run(32, 48, 1'b1);
    chk("shutdown wait", busy_cyc, LW + SW);
    chk("mask 48", fmask, 32'h0000_0003);
    chk("value 48", fval, 32'h0000_0000);
    rd(DPS_REG_DELAY_LEFT, 32'h0000_0000, "delay left");
  endtask
  task automatic t_disabled;
    wr(DPS_REG_CTRL, 32'h2);
    run(6'd28, 1'b0);
    chk_run(28, 63, 1'b0);
    rd(DPS_REG_FETCH_COUNT, 32'd36, "count");
    chk("mask off", fmask, 32'h0000_0000);
    chk("value off", fval, 32'h0000_0000);
    rd(DPS_REG_STATUS, 32'h3F00, "status off");
    wr(DPS_REG_CTRL, 32'h1);
    wr(DPS_REG_TABLE_INDEX, 32'd47);
    rd(DPS_REG_TABLE_INDEX, 32'd47, "table index");
    rd(DPS_REG_TABLE_ENTRY, {4'h0, tbl[47]}, "table 47");
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_startup();
    t_shutdown();
    t_disabled();
    results();
  end
endmodule
